// ==== mos_pkg.sv ====
// Purpose: constants and types shared by the meter output stage
// Assumes: 125 MHz clock, register port with one-cycle read latency
// Notes: values are signed 32-bit fixed point as delivered by the measurement side
//
// Behaviour
// - relay contact stays open while no relay function is configured.
// - configured relay holds contact closed, opens only when function triggers.
// - relay setup order: variable, then lower point, then upper point.
// - contact opens while variable lies between points, closed above upper point.
// - relay source: flow, flow rate, temperature difference, T1, T2, sound speed.
// - pulse source: total volume, heat quantity or total mass.
// - pulse width chosen from 20, 40, 60, 100, 260 or 500 ms.
// - surplus owed pulses are buffered and emitted as soon as possible.
// - buffer holds 4096 pulses; beyond that output stops, overflow error set.
// - while overflow error is set, nothing is emitted or buffered.
// - overflow never alters totalizer values; totals keep accumulating.
// - explicit clear of the overflow error re-enables pulse emission.
// - two-channel build has a second independent pulse output per path.
// - totalizer unit change converts pending count to new unit.
// - character: start, eight data bits, optional odd/even parity, one stop.
// - bit rate defaults 9600; 9600 to 115200 selectable.
// - record transmission disabled after reset until operator enables it.
// - record interval hh:mm:ss, default one second.
// - serial factory reset restores every serial setting to default.
// - records are sent as ASCII characters.
// - record holds thirteen semicolon-separated fields in fixed order.
`default_nettype none

package mos_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned SEC_CYCLES = CLK_HZ;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] A_RLY_SRC = 8'h00;
    localparam logic [7:0] A_RLY_LO = 8'h04;
    localparam logic [7:0] A_RLY_HI = 8'h08;
    localparam logic [7:0] A_PLS_CFG = 8'h0c;
    localparam logic [7:0] A_PLS_WGT = 8'h10;
    localparam logic [7:0] A_PLS_CTL = 8'h14;
    localparam logic [7:0] A_PLS_STAT = 8'h18;
    localparam logic [7:0] A_SER_CFG = 8'h1c;
    localparam logic [7:0] A_SER_IVL = 8'h20;
    localparam logic [7:0] A_REC_DATA = 8'h24;
    localparam logic [7:0] A_STATUS = 8'h28;
    localparam logic [7:0] A_UNIT_CONV = 8'h2c;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned PCTL_CLR_BIT = 0;
    localparam int unsigned PCTL_CONV_BIT = 1;
    localparam int unsigned SCFG_EN_BIT = 0;
    localparam int unsigned SCFG_FRST_BIT = 7;
    localparam logic [2:0] BAUD_RST = 3'h0;
    localparam logic [1:0] PAR_RST = 2'h0;
    localparam logic [16:0] IVL_RST = 17'h00001;
    localparam int unsigned BUF_DEPTH = 4096;

    typedef enum logic [2:0] {
        MOS_SRC_FLOW = 3'h0, MOS_SRC_RATE = 3'h1, MOS_SRC_TDIFF = 3'h2,
        MOS_SRC_T1 = 3'h3, MOS_SRC_T2 = 3'h4, MOS_SRC_VS = 3'h5
    } mos_src_t;

    typedef enum logic [1:0] {
        MOS_PAR_NONE = 2'h0, MOS_PAR_ODD = 2'h1, MOS_PAR_EVEN = 2'h2
    } mos_par_t;

    // rate table: 9600 19200 38400 56000 57600 115200
    function automatic logic [15:0] mos_baud_div(input logic [2:0] sel);
        case (sel)
            3'h1: mos_baud_div = 16'(CLK_HZ / 19200);
            3'h2: mos_baud_div = 16'(CLK_HZ / 38400);
            3'h3: mos_baud_div = 16'(CLK_HZ / 56000);
            3'h4: mos_baud_div = 16'(CLK_HZ / 57600);
            3'h5: mos_baud_div = 16'(CLK_HZ / 115200);
            default: mos_baud_div = 16'(CLK_HZ / 9600);
        endcase
    endfunction : mos_baud_div

    // widths 20 40 60 100 260 500 ms
    function automatic logic [25:0] mos_width_cyc(input logic [2:0] sel);
        case (sel)
            3'h1: mos_width_cyc = 26'(40 * MS_CYCLES);
            3'h2: mos_width_cyc = 26'(60 * MS_CYCLES);
            3'h3: mos_width_cyc = 26'(100 * MS_CYCLES);
            3'h4: mos_width_cyc = 26'(260 * MS_CYCLES);
            3'h5: mos_width_cyc = 26'(500 * MS_CYCLES);
            default: mos_width_cyc = 26'(20 * MS_CYCLES);
        endcase
    endfunction : mos_width_cyc
endpackage : mos_pkg

`default_nettype wire

// ==== mos_pulse_if.sv ====
// Purpose: carrier between top and a pulse channel
// Assumes: single clock
// Notes: config from top, status back
`default_nettype none

interface mos_pulse_if;
    logic [31:0] total;
    logic [31:0] weight;
    logic [2:0] width_sel;
    logic clear;
    logic conv;
    logic [31:0] conv_mul;
    logic pulse;
    logic err;
    logic [12:0] pending;
    modport top (output total, weight, width_sel, clear, conv, conv_mul,
                 input pulse, err, pending);
    modport chan (input total, weight, width_sel, clear, conv, conv_mul,
                  output pulse, err, pending);
endinterface : mos_pulse_if

`default_nettype wire

// ==== mos_pulse_chan.sv ====
// Purpose: one pulse output channel with pending buffer and overflow latch
// Assumes: total is a monotonic accumulated count from the totalizer
// Notes: pending count replaces a stored queue; pulses carry no data
`default_nettype none

module mos_pulse_chan
    import mos_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // channel port
    mos_pulse_if.chan p
);
    typedef enum logic [1:0] {MOS_PC_IDLE = 2'b00, MOS_PC_HIGH = 2'b01,
                              MOS_PC_LOW = 2'b11} mos_pc_st_t;
    typedef struct packed {
        mos_pc_st_t st;
        logic [25:0] cnt;
        logic [31:0] acc;
        logic [31:0] last;
        logic [12:0] pend;
        logic err;
        logic pulse;
    } mos_pc_t;

    mos_pc_t s_r, s_nxt;
    logic [31:0] delta;
    logic [31:0] acc_sum;
    logic owed;
    logic [63:0] prod;

    always_comb
    begin
        s_nxt = s_r;
        delta = p.total - s_r.last;
        acc_sum = s_r.acc + delta;
        owed = 1'b0;
        prod = 64'(s_r.pend) * 64'(p.conv_mul);
        s_nxt.last = p.total;
        // one pulse owed per full weight step
        if (p.weight != 32'h0 && acc_sum >= p.weight)
        begin
            owed = 1'b1;
            s_nxt.acc = acc_sum - p.weight;
        end
        else
        begin
            s_nxt.acc = acc_sum;
        end
        case (s_r.st)
            MOS_PC_HIGH:
            begin
                if (s_r.cnt == 26'h1)
                begin
                    s_nxt.st = MOS_PC_LOW;
                    s_nxt.cnt = mos_width_cyc(p.width_sel);
                    s_nxt.pulse = 1'b0;
                end
                else
                    s_nxt.cnt = s_r.cnt - 26'h1;
            end
            MOS_PC_LOW:
            begin
                // equal gap keeps pulses apart
                if (s_r.cnt == 26'h1)
                    s_nxt.st = MOS_PC_IDLE;
                else
                    s_nxt.cnt = s_r.cnt - 26'h1;
            end
            MOS_PC_IDLE:
            begin
                if (s_r.pend != 13'h0 && !s_r.err)
                begin
                    s_nxt.st = MOS_PC_HIGH;
                    s_nxt.cnt = mos_width_cyc(p.width_sel);
                    s_nxt.pulse = 1'b1;
                    s_nxt.pend = s_r.pend - 13'h1;
                end
            end
            default: s_nxt.st = MOS_PC_IDLE;
        endcase
        if (owed && !s_r.err)
        begin
            if (s_nxt.pend == 13'(BUF_DEPTH))
            begin
                // overflow: drop all, stop output
                s_nxt.err = 1'b1;
                s_nxt.pend = 13'h0;
            end
            else
                s_nxt.pend = s_nxt.pend + 13'h1;
        end
        if (s_r.err)
            s_nxt.pend = 13'h0;
        // rescale pending on unit change, conv_mul is 16.16
        if (p.conv)
            s_nxt.pend = (prod[47:16] > 32'(BUF_DEPTH)) ? 13'(BUF_DEPTH) : prod[28:16];
        // clear loses to a new overflow in the same cycle
        if (p.clear && !(owed && s_nxt.err && !s_r.err))
            s_nxt.err = 1'b0;
        // overflow cuts a running pulse short
        if (s_nxt.err)
        begin
            s_nxt.st = MOS_PC_IDLE;
            s_nxt.pulse = 1'b0;
        end
        if (!i_reset_n)
        begin
            s_nxt = '0;
            s_nxt.st = MOS_PC_IDLE;
            s_nxt.last = p.total;
        end
    end

    always_ff @(posedge i_clk)
        s_r <= s_nxt;

    assign p.pulse = s_r.pulse;
    assign p.err = s_r.err;
    assign p.pending = s_r.pend;

    pend_cap_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_r.pend <= 13'(BUF_DEPTH)) else $error("pending count above buffer size");
    err_silent_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_r.err && !p.clear |=> s_r.pend == 13'h0 && !$rose(s_r.pulse))
        else $error("pulse activity while overflow set");
endmodule : mos_pulse_chan

`default_nettype wire

// ==== mos_top.sv ====
// Purpose: relay, pulse outputs and serial record sender of the meter
// Assumes: measured values arrive as same-clock 32-bit words
// Notes: record characters are fed by software through a data register
//
// The implementer's own choices: the register addresses and the strobed register port.
`default_nettype none

module mos_top
    import mos_pkg::*;
#(
    parameter int unsigned CHANNELS = 2,
    parameter int unsigned SEC_CYC = SEC_CYCLES
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // measured values
    input wire logic [31:0] i_flow,
    input wire logic [31:0] i_flow_rate,
    input wire logic [31:0] i_temp_one,
    input wire logic [31:0] i_temp_two,
    input wire logic [31:0] i_sound_speed,
    input wire logic [31:0] i_tot_volume [CHANNELS],
    input wire logic [31:0] i_tot_heat [CHANNELS],
    input wire logic [31:0] i_tot_mass [CHANNELS],
    // outputs
    output logic o_relay_closed,
    output logic [CHANNELS-1:0] o_pulse,
    output logic o_txd
);
    initial
    begin
        if (CHANNELS < 1 || CHANNELS > 2)
            $error("CHANNELS must be 1 or 2");
        if (SEC_CYC < 2)
            $error("SEC_CYC too small");
    end

    typedef enum logic [1:0] {MOS_TX_IDLE = 2'b00, MOS_TX_START = 2'b01,
                              MOS_TX_DATA = 2'b11, MOS_TX_STOP = 2'b10} mos_tx_st_t;

    typedef struct packed {
        logic [2:0] rly_src;
        logic [1:0] rly_step;
        logic signed [31:0] rly_lo;
        logic signed [31:0] rly_hi;
        logic relay;
        logic [3:0] pls_src;
        logic [5:0] width_sel;
        logic [63:0] weight;
        logic [1:0] clear;
        logic conv;
        logic [31:0] conv_mul;
        logic ser_en;
        logic [2:0] baud;
        logic [1:0] par;
        logic [16:0] ivl;
        logic [16:0] sec_cnt;
        logic [31:0] tick;
        logic rec_due;
        logic [7:0] fifo_ch;
        logic ch_valid;
        mos_tx_st_t tx_st;
        logic [15:0] baud_cnt;
        logic [3:0] bit_idx;
        logic [8:0] shreg;
        logic txd;
        logic [31:0] rdata;
    } mos_top_t;

    mos_top_t s_r, s_nxt;
    mos_pulse_if pif [CHANNELS] ();
    logic signed [31:0] rly_val;
    logic [CHANNELS-1:0] pls_q, err_q;
    logic [12:0] pend_q [CHANNELS];

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_chan
            // each path drives its own output
            always_comb
            begin
                case (s_r.pls_src[2*gi +: 2])
                    2'h1: pif[gi].total = i_tot_heat[gi];
                    2'h2: pif[gi].total = i_tot_mass[gi];
                    default: pif[gi].total = i_tot_volume[gi];
                endcase
            end
            assign pif[gi].weight = s_r.weight[32*gi +: 32];
            assign pif[gi].width_sel = s_r.width_sel[3*gi +: 3];
            assign pif[gi].clear = s_r.clear[gi];
            assign pif[gi].conv = s_r.conv;
            assign pif[gi].conv_mul = s_r.conv_mul;
            assign pls_q[gi] = pif[gi].pulse;
            assign err_q[gi] = pif[gi].err;
            assign pend_q[gi] = pif[gi].pending;
            mos_pulse_chan u_chan (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .p(pif[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // relay source select
    // ------------------------------------------------------------------
    always_comb
    begin
        case (s_r.rly_src)
            MOS_SRC_RATE: rly_val = i_flow_rate;
            MOS_SRC_TDIFF: rly_val = i_temp_two - i_temp_one;
            MOS_SRC_T1: rly_val = i_temp_one;
            MOS_SRC_T2: rly_val = i_temp_two;
            MOS_SRC_VS: rly_val = i_sound_speed;
            default: rly_val = i_flow;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.clear = '0;
        s_nxt.conv = 1'b0;
        s_nxt.rdata = '0;

        // writes
        if (i_wr)
        begin
            case (i_addr)
                A_RLY_SRC:
                begin
                    // new variable restarts the setup sequence
                    s_nxt.rly_src = i_wdata[2:0];
                    s_nxt.rly_step = 2'h1;
                end
                A_RLY_LO:
                    if (s_r.rly_step == 2'h1)
                    begin
                        s_nxt.rly_lo = i_wdata;
                        s_nxt.rly_step = 2'h2;
                    end
                A_RLY_HI:
                    if (s_r.rly_step == 2'h2)
                    begin
                        s_nxt.rly_hi = i_wdata;
                        s_nxt.rly_step = 2'h3;
                    end
                A_PLS_CFG:
                begin
                    s_nxt.pls_src = i_wdata[3:0];
                    s_nxt.width_sel = i_wdata[13:8];
                end
                A_PLS_WGT: s_nxt.weight[32*i_wdata[31] +: 32] = {1'b0, i_wdata[30:0]};
                A_PLS_CTL:
                begin
                    if (i_wdata[PCTL_CLR_BIT])
                        s_nxt.clear = 2'(i_wdata[17:16]);
                    s_nxt.conv = i_wdata[PCTL_CONV_BIT];
                end
                A_UNIT_CONV: s_nxt.conv_mul = i_wdata;
                A_SER_CFG:
                begin
                    s_nxt.ser_en = i_wdata[SCFG_EN_BIT];
                    s_nxt.baud = (i_wdata[3:1] > 3'h5) ? BAUD_RST : i_wdata[3:1];
                    s_nxt.par = (i_wdata[5:4] == 2'h3) ? PAR_RST : i_wdata[5:4];
                    if (i_wdata[SCFG_FRST_BIT])
                    begin
                        // factory defaults
                        s_nxt.ser_en = 1'b0;
                        s_nxt.baud = BAUD_RST;
                        s_nxt.par = PAR_RST;
                        s_nxt.ivl = IVL_RST;
                    end
                end
                A_SER_IVL:
                    if (i_wdata[4:0] < 5'd24 && i_wdata[13:8] < 6'd60 && i_wdata[21:16] < 6'd60)
                        s_nxt.ivl = 17'(i_wdata[4:0] * 3600 + i_wdata[13:8] * 60
                                        + i_wdata[21:16]);
                A_REC_DATA:
                    if (!s_r.ch_valid)
                    begin
                        s_nxt.fifo_ch = i_wdata[7:0]; // ascii byte
                        s_nxt.ch_valid = 1'b1;
                    end
                default: ;
            endcase
        end

        // reads
        if (i_rd)
        begin
            case (i_addr)
                A_RLY_SRC: s_nxt.rdata = {28'h0, s_r.rly_step, 2'h0} | 32'(s_r.rly_src);
                A_RLY_LO: s_nxt.rdata = s_r.rly_lo;
                A_RLY_HI: s_nxt.rdata = s_r.rly_hi;
                A_PLS_CFG: s_nxt.rdata = {18'h0, s_r.width_sel, 4'h0, s_r.pls_src};
                A_PLS_STAT: s_nxt.rdata = {pend_q[CHANNELS-1], 2'h0, pend_q[0],
                                           2'(err_q), 2'(pls_q)};
                A_SER_CFG: s_nxt.rdata = {26'h0, s_r.par, s_r.baud, s_r.ser_en};
                A_SER_IVL: s_nxt.rdata = {15'h0, s_r.ivl};
                A_STATUS: s_nxt.rdata = {29'h0, s_r.rec_due, s_r.ch_valid, s_r.relay};
                A_UNIT_CONV: s_nxt.rdata = s_r.conv_mul;
                default: s_nxt.rdata = '0;
            endcase
        end

        // relay: closed when armed, open inside the band
        if (s_r.rly_step != 2'h3)
            s_nxt.relay = 1'b0;
        else if (rly_val >= s_r.rly_lo && rly_val <= s_r.rly_hi)
            s_nxt.relay = 1'b0;
        else
            s_nxt.relay = 1'b1;

        // record timer, held idle until enabled
        if (!s_r.ser_en)
        begin
            s_nxt.tick = '0;
            s_nxt.sec_cnt = '0;
            s_nxt.rec_due = 1'b0;
        end
        else if (s_r.tick == 32'(SEC_CYC - 1))
        begin
            s_nxt.tick = '0;
            if (s_r.sec_cnt + 17'h1 >= s_r.ivl)
            begin
                s_nxt.sec_cnt = '0;
                s_nxt.rec_due = 1'b1;
            end
            else
                s_nxt.sec_cnt = s_r.sec_cnt + 17'h1;
        end
        else
            s_nxt.tick = s_r.tick + 32'h1;
        // read clears the flag; a tick in the same cycle wins
        if (i_rd && i_addr == A_STATUS && !(s_r.ser_en && s_r.tick == 32'(SEC_CYC - 1)))
            s_nxt.rec_due = 1'b0;

        // transmitter 8 data bits, optional parity, one stop
        case (s_r.tx_st)
            MOS_TX_IDLE:
            begin
                s_nxt.txd = 1'b1;
                if (s_r.ch_valid && s_r.ser_en)
                begin
                    s_nxt.shreg = {(s_r.par == MOS_PAR_ODD) ? ~^s_r.fifo_ch : ^s_r.fifo_ch,
                                   s_r.fifo_ch};
                    s_nxt.ch_valid = 1'b0;
                    s_nxt.tx_st = MOS_TX_START;
                    s_nxt.baud_cnt = mos_baud_div(s_r.baud) - 16'h1;
                    s_nxt.txd = 1'b0;
                end
            end
            MOS_TX_START, MOS_TX_DATA:
            begin
                if (s_r.baud_cnt == 16'h0)
                begin
                    s_nxt.baud_cnt = mos_baud_div(s_r.baud) - 16'h1;
                    if (s_r.tx_st == MOS_TX_START)
                    begin
                        s_nxt.tx_st = MOS_TX_DATA;
                        s_nxt.bit_idx = 4'h0;
                        s_nxt.txd = s_r.shreg[0];
                    end
                    else if (s_r.bit_idx == ((s_r.par == MOS_PAR_NONE) ? 4'h7 : 4'h8))
                    begin
                        s_nxt.tx_st = MOS_TX_STOP;
                        s_nxt.txd = 1'b1;
                    end
                    else
                    begin
                        s_nxt.bit_idx = s_r.bit_idx + 4'h1;
                        s_nxt.txd = s_r.shreg[s_r.bit_idx + 4'h1];
                    end
                end
                else
                    s_nxt.baud_cnt = s_r.baud_cnt - 16'h1;
            end
            MOS_TX_STOP:
            begin
                if (s_r.baud_cnt == 16'h0)
                    s_nxt.tx_st = MOS_TX_IDLE;
                else
                    s_nxt.baud_cnt = s_r.baud_cnt - 16'h1;
            end
            default: s_nxt.tx_st = MOS_TX_IDLE;
        endcase

        if (!i_reset_n)
        begin
            s_nxt = '0;
            s_nxt.tx_st = MOS_TX_IDLE;
            s_nxt.txd = 1'b1;
            s_nxt.ivl = IVL_RST;
            s_nxt.baud = BAUD_RST;
            s_nxt.par = PAR_RST;
            s_nxt.conv_mul = 32'h0001_0000;
            s_nxt.ser_en = 1'b0;
        end
    end

    always_ff @(posedge i_clk)
        s_r <= s_nxt;

    // outputs registered here; pulse lines come from channel flops
    always_ff @(posedge i_clk)
    begin
        o_rdata <= s_nxt.rdata;
        o_relay_closed <= s_nxt.relay;
        o_txd <= s_nxt.txd;
        o_pulse <= i_reset_n ? pls_q : '0;
    end

    relay_open_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_r.rly_step != 2'h3 |=> !s_r.relay) else $error("relay closed unconfigured");
    relay_band_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_r.rly_step == 2'h3 && rly_val > s_r.rly_hi |=> s_r.relay)
        else $error("relay open above upper point");
    ser_quiet_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !s_r.ser_en && s_r.tx_st == MOS_TX_IDLE |=> s_r.txd)
        else $error("line active while disabled");
    rec_timer_idle_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !s_r.ser_en |=> s_r.tick == 32'h0 && !s_r.rec_due)
        else $error("record timer running while disabled");
endmodule : mos_top

`default_nettype wire

// ==== mos_far_model.sv ====
// Purpose: far side: serial terminal and pulse counter
// Assumes: eight data bits, no parity, one stop bit
// Notes: listens only, drives nothing back
`default_nettype none

module mos_far_model #(
    parameter int BIT_CYC = 1085
)
(
    // watched lines
    input wire logic i_clk,
    input wire logic i_txd,
    input wire logic i_pulse,
    // results
    output logic [7:0] o_byte,
    output logic o_stop_ok,
    output int o_n_char,
    output int o_n_pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_n_char = 0;
        o_n_pulse = 0;
        o_byte = 8'h00;
        o_stop_ok = 1'b0;
        forever
        begin
            @(negedge i_txd);
            // sample mid-bit, clear of edges
            repeat (BIT_CYC + BIT_CYC / 2) @(posedge i_clk);
            for (int i = 0; i < 8; i++)
            begin
                o_byte[i] = i_txd;
                repeat (BIT_CYC) @(posedge i_clk);
            end
            o_stop_ok = i_txd;
            o_n_char++;
        end
    end

    always @(posedge i_pulse)
        o_n_pulse++;
endmodule : mos_far_model

`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench of the meter output stage
// Assumes: SEC_CYC shortened, serial at 115200
// Notes: pulse widths are not waited out, too long
`default_nettype none

module testbench
    import mos_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_reset_n, i_wr, i_rd, o_relay_closed, o_txd, stop_ok;
    logic [7:0] i_addr, rx_byte;
    logic [31:0] i_wdata, o_rdata, d, sel;
    logic [31:0] v [6];
    logic [31:0] i_tot_volume [2];
    logic [31:0] i_tot_heat [2];
    logic [31:0] i_tot_mass [2];
    logic [1:0] o_pulse;
    int n_char, n_pulse, n_mismatch, total_checks, seed, k;

    mos_top #(.CHANNELS(2), .SEC_CYC(10)) i_mos_top (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_flow(v[0]), .i_flow_rate(v[1]), .i_temp_one(v[3]), .i_temp_two(v[4]),
        .i_sound_speed(v[5]), .i_tot_volume(i_tot_volume), .i_tot_heat(i_tot_heat),
        .i_tot_mass(i_tot_mass), .o_relay_closed(o_relay_closed), .o_pulse(o_pulse),
        .o_txd(o_txd));
    mos_far_model #(.BIT_CYC(1085)) i_mos_far_model (.i_clk(i_clk), .i_txd(o_txd),
        .i_pulse(o_pulse[0]), .o_byte(rx_byte), .o_stop_ok(stop_ok), .o_n_char(n_char),
        .o_n_pulse(n_pulse));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= w;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        r = o_rdata;
    endtask : rd

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    // contact open inside the closed range, boundaries included
    function automatic logic relay_exp(input logic [31:0] x);
        relay_exp = !($signed(x) >= 0 && $signed(x) <= 150);
    endfunction : relay_exp

    initial
    begin
        i_clk = 1'b0;
        forever
            #4 i_clk = ~i_clk;
    end

    initial
    begin
        repeat (100000) @(posedge i_clk);
        n_mismatch++;
        results();
    end

    initial
    begin
        seed = 32'ha4c2;
        {i_reset_n, i_wr, i_rd, i_addr, i_wdata} = '0;
        v = '{default: 32'h0};
        i_tot_volume = '{default: 32'h0};
        i_tot_heat = '{default: 32'h0};
        i_tot_mass = '{default: 32'h0};
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        chk(o_relay_closed, 0, "relay idle");
        wr(8'hf0, 32'hffffffff);
        for (int s = 0; s < 6; s++)
        begin
            wr(A_RLY_SRC, s);
            wr(A_RLY_LO, 32'h0);
            wr(A_RLY_HI, 32'd150);
            for (int j = 0; j < 8; j++)
            begin
                for (int m = 0; m < 6; m++)
                    v[m] <= (j == 0) ? 32'd150 : $random(seed) % 300;
                repeat (3) @(posedge i_clk);
                #1;
                sel = (s == 2) ? v[4] - v[3] : v[s];
                chk(o_relay_closed, relay_exp(sel), "relay");
            end
        end
        $display("relay test done");
        wr(A_PLS_CFG, 32'h0);
        wr(A_PLS_WGT, 32'h1);
        i_tot_volume[0] <= 32'd5000;
        d = 0;
        for (k = 0; k < 4000 && d[2] !== 1'b1; k++)
            rd(A_PLS_STAT, d);
        chk(d[2], 1, "overflow flag");
        chk(o_pulse, 0, "pulse during error");
        wr(A_PLS_CTL, 32'h00030001);
        rd(A_PLS_STAT, d);
        chk(d[2], 0, "overflow cleared");
        i_tot_volume[0] <= 32'd5001;
        for (k = 0; k < 300 && o_pulse[0] !== 1'b1; k++)
            @(posedge i_clk);
        #1;
        chk(o_pulse, 2'b01, "pulse resumed");
        chk(n_pulse, 2, "pulse count");
        $display("pulse test done");
        chk(n_char, 0, "no record before enable");
        wr(A_SER_CFG, 32'h0b);
        wr(A_REC_DATA, 32'h41);
        for (k = 0; k < 15000 && n_char == 0; k++)
            @(posedge i_clk);
        chk(rx_byte, 8'h41, "serial char");
        chk(stop_ok, 1, "stop bit");
        $display("serial test done");
        results();
    end
endmodule : testbench

`default_nettype wire
